// ---- verilog/trip_defines.svh ----
// Constants for the trip status and history logger.
// Assumes inclusion by bare name from design files only.
`ifndef TRIP_DEFINES_SVH
`define TRIP_DEFINES_SVH

`define HIST_DEPTH       4
`define HIST_SLOTS       10
`define CODE_W           4
`define TRIP_BITS        14

`define ADR_CTRL         6'h00
`define ADR_DISABLED     6'h01
`define ADR_ACTIVE       6'h02
`define ADR_WARN         6'h03
`define ADR_FIRST        6'h04
`define ADR_HIST0        6'h08
`define ADR_HIST_LAST    6'h11

`define CTRL_TRIP_RESET  0
`define CTRL_HIST_CLEAR  1

// Bit set for trip codes 5..8 and 10..13 (codes that may be disabled)
`define DISABLEABLE_MASK 16'h3DE0
// Bits 1..13 carry trips; bit 0 and bits 14..15 name no trip
`define TRIP_VALID       16'h3FFE
`define CODE_NONE        4'h0
`define ZERO16           16'h0000
`define ZERO32           32'h0000_0000
`define ONE_CODE         4'h1

`endif

// ---- verilog/trip_pkg.sv ----
// Types shared by the trip logger files.
// Assumes trip_defines.svh is on the include path.
`include "trip_defines.svh"
package trip_pkg;
  typedef logic [`CODE_W-1:0]    trip_code_t;
  typedef logic [15:0]           trip_word_t;
  typedef logic [`HIST_DEPTH-1:0] slot_idx_t;
endpackage

// ---- verilog/hist_mem.sv ----
// Ten-slot shift register holding the trip history, newest in slot 0.
// Assumes retention across supply loss is provided by the storage cell
// technology; reset does not clear it, only an explicit clear does.
`timescale 1ns/1ps
`include "trip_defines.svh"
module hist_mem
  import trip_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 push_i,
  input  wire logic                 clear_i,
  input  wire trip_pkg::trip_code_t code_i,
  input  wire trip_pkg::slot_idx_t  rd_idx_i,
  output logic [`CODE_W-1:0]        rd_data_o
);
  trip_code_t slot [`HIST_SLOTS];
  trip_code_t next_slot [`HIST_SLOTS];
  trip_code_t next_rd;

  // ==========================================================
  // Shift
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < `HIST_SLOTS; g++) begin : g_slot
      trip_code_t shift_in;
      // Chosen at elaboration so slot 0 never names a slot below it
      if (g == 0) begin : g_head
        assign shift_in = code_i;
      end else begin : g_tail
        assign shift_in = slot[g-1];
      end
      always_comb begin
        if (clear_i) begin
          next_slot[g] = `CODE_NONE;
        end else if (push_i) begin
          next_slot[g] = shift_in;
        end else begin
          next_slot[g] = slot[g];
        end
      end
      // No reset: contents survive power loss and trip reset
      always_ff @(posedge clk_i) begin
        slot[g] <= next_slot[g];
      end
    end
  endgenerate

  // ==========================================================
  // Registered read port
  // ==========================================================
  always_comb begin
    if (rd_idx_i < slot_idx_t'(`HIST_SLOTS)) begin
      next_rd = slot[rd_idx_i];
    end else begin
      next_rd = `CODE_NONE;
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_o <= next_rd;
  end
endmodule

// ---- verilog/first_trip_latch.sv ----
// Records the first trip detected and flags its arrival once, or every cycle that rst_i is held with a trip present.
// Assumes trip conditions are already masked by the caller.
`timescale 1ns/1ps
`include "trip_defines.svh"
module first_trip_latch
  import trip_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 trip_reset_i,
  input  wire trip_pkg::trip_word_t trips_i,
  output trip_pkg::trip_code_t      first_o,
  output logic                      new_trip_o
);
  trip_code_t first;
  trip_code_t next_first;
  trip_code_t lowest;

  // Lowest code wins when several arrive in the same cycle
  always_comb begin
    lowest = `CODE_NONE;
    for (int i = `TRIP_BITS - 1; i >= 1; i--) begin
      if (trips_i[i]) begin
        lowest = trip_code_t'(i);
      end
    end
  end

  always_comb begin
    next_first = first;
    if (trip_reset_i) begin
      next_first = `CODE_NONE;
    end else if (first == `CODE_NONE) begin
      next_first = lowest;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first <= `CODE_NONE;
    end else begin
      first <= next_first;
    end
  end

  assign first_o    = first;
  // One push per zero-to-nonzero change of the latched code, and one per cycle while rst_i is held with a trip present
  assign new_trip_o = (first == `CODE_NONE) && !trip_reset_i &&
                      (lowest != `CODE_NONE);
endmodule

// ---- verilog/trip_status_history_logger.sv ----
// Trip supervision: first-trip latch, active/warning/disabled words and
// a ten-deep trip history, all reached over a classic Wishbone slave.
// Assumes trip and warning inputs are synchronous levels, bit n = code n.
`timescale 1ns/1ps
`include "trip_defines.svh"
module trip_status_history_logger
  import trip_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire trip_pkg::trip_word_t trip_cond_i,
  input  wire trip_pkg::trip_word_t warn_cond_i,
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [5:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic [31:0]               dat_o,
  output logic                      ack_o,
  output trip_pkg::trip_code_t      first_trip_o,
  output logic                      stop_o
);
  import trip_pkg::*;

  trip_word_t disabled;
  trip_word_t next_disabled;
  trip_word_t active;
  trip_word_t next_active;
  trip_word_t warn;
  trip_word_t next_warn;
  logic       ack;
  logic       next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic       trip_reset;
  logic       hist_clear;
  logic       hist_sel;
  logic       new_trip;
  logic       wr_req;
  logic       rd_hist;
  logic       next_rd_hist;
  trip_word_t effective_mask;
  trip_word_t live_trips;
  trip_code_t first;
  slot_idx_t  hist_idx;
  logic [`CODE_W-1:0] hist_rd;

  // ==========================================================
  // Trip masking
  // ==========================================================
  // Mask bits of never-disableable trips are stored but have no effect
  assign effective_mask = disabled & `DISABLEABLE_MASK;
  assign live_trips     = trip_cond_i & ~effective_mask & `TRIP_VALID;

  always_comb begin
    next_active = live_trips;
    next_warn   = warn_cond_i & `TRIP_VALID;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active <= `ZERO16;
      warn   <= `ZERO16;
    end else begin
      active <= next_active;
      warn   <= next_warn;
    end
  end

  // ==========================================================
  // First trip and history
  // ==========================================================
  first_trip_latch u_first (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .trip_reset_i (trip_reset),
    .trips_i      (live_trips),
    .first_o      (first),
    .new_trip_o   (new_trip)
  );

  assign hist_sel = (adr_i >= `ADR_HIST0) && (adr_i <= `ADR_HIST_LAST);
  assign hist_idx = slot_idx_t'(adr_i - `ADR_HIST0);

  // Code pushed is the one about to be latched as first trip
  hist_mem u_hist (
    .clk_i     (clk_i),
    .push_i    (new_trip),
    .clear_i   (hist_clear),
    .code_i    (lowest_code(live_trips)),
    .rd_idx_i  (hist_idx),
    .rd_data_o (hist_rd)
  );

  function automatic trip_code_t lowest_code(input trip_word_t w);
    trip_code_t c;
    c = `CODE_NONE;
    for (int i = `TRIP_BITS - 1; i >= 1; i--) begin
      if (w[i]) begin
        c = trip_code_t'(i);
      end
    end
    return c;
  endfunction

  assign first_trip_o = first;
  assign stop_o       = (first != `CODE_NONE);

  // ==========================================================
  // Wishbone slave
  // ==========================================================
  // Answer one cycle after the request; the history read port is
  // registered, so its data is muxed in on the ack cycle.
  assign wr_req     = cyc_i && stb_i && we_i && !ack;
  assign trip_reset = wr_req && (adr_i == `ADR_CTRL) && sel_i[0] &&
                      dat_i[`CTRL_TRIP_RESET];
  assign hist_clear = wr_req && (adr_i == `ADR_CTRL) && sel_i[0] &&
                      dat_i[`CTRL_HIST_CLEAR];

  always_comb begin
    next_ack      = cyc_i && stb_i && !ack;
    next_disabled = disabled;
    next_rdata    = `ZERO32;
    next_rd_hist  = 1'b0;
    if (wr_req && (adr_i == `ADR_DISABLED)) begin
      if (sel_i[0]) begin
        next_disabled[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        next_disabled[15:8] = dat_i[15:8];
      end
    end
    if (cyc_i && stb_i && !we_i && !ack) begin
      unique case (adr_i)
        `ADR_DISABLED: next_rdata = {16'h0000, disabled};
        `ADR_ACTIVE:   next_rdata = {16'h0000, active};
        `ADR_WARN:     next_rdata = {16'h0000, warn};
        `ADR_FIRST:    next_rdata = {28'h000_0000, first};
        default: begin
          next_rdata   = `ZERO32;
          next_rd_hist = hist_sel;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disabled <= `ZERO16;
      ack      <= 1'b0;
      rdata    <= `ZERO32;
      rd_hist  <= 1'b0;
    end else begin
      disabled <= next_disabled;
      ack      <= next_ack;
      rdata    <= next_rdata;
      rd_hist  <= next_rd_hist;
    end
  end

  assign ack_o = ack;
  assign dat_o = rd_hist ? {28'h000_0000, hist_rd} : rdata;
endmodule

// ---- test/trip_checker.sv ----
// Checker for the trip logger: bus timing and first-trip latch.
// Assumes it is bound to trip_status_history_logger.
`timescale 1ns/1ps
module trip_checker
  import trip_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire trip_pkg::trip_word_t trip_cond_i,
  input wire logic                 cyc_i,
  input wire logic                 stb_i,
  input wire logic                 we_i,
  input wire logic [5:0]           adr_i,
  input wire logic [3:0]           sel_i,
  input wire logic [31:0]          dat_i,
  input wire logic [31:0]          dat_o,
  input wire logic                 ack_o,
  input wire trip_pkg::trip_code_t first_trip_o,
  input wire logic                 stop_o
);
  // ==========================================================
  // Helpers
  logic tk;
  logic clr;
  assign tk  = cyc_i & stb_i & ~ack_o;
  assign clr = tk & we_i & adr_i == 6'h00 & sel_i[0] & dat_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Properties
  property p_ack; tk |=> ack_o; endproperty
  a_ack: assert property (p_ack)
    else $error("no ack one cycle after request");
  property p_one; ack_o |=> !ack_o; endproperty
  a_one: assert property (p_one)
    else $error("ack longer than one cycle");
  property p_stop; stop_o == (first_trip_o != 4'h0); endproperty
  a_stop: assert property (p_stop)
    else $error("stop does not follow first trip");
  property p_hold;
    first_trip_o != 4'h0 && !clr |=> $stable(first_trip_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("first trip changed without reset");
  property p_clr; clr |=> first_trip_o == 4'h0; endproperty
  a_clr: assert property (p_clr)
    else $error("trip reset did not clear first trip");
  property p_one_first;
    first_trip_o == 4'h0 && trip_cond_i[1] && !clr |=> first_trip_o == 4'h1;
  endproperty
  a_one_first: assert property (p_one_first)
    else $error("code 1 trip not latched");
  property p_idle;
    first_trip_o == 4'h0 && trip_cond_i[13:1] == 13'h0000 |=>
      first_trip_o == 4'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("first trip set with no trip present");
  property p_rdfirst;
    tk && !we_i && adr_i == 6'h04 |=>
      dat_o == {28'h000_0000, $past(first_trip_o)};
  endproperty
  a_rdfirst: assert property (p_rdfirst)
    else $error("first trip read back wrong");
endmodule
bind trip_status_history_logger trip_checker chk (
  .clk_i        (clk_i),
  .rst_i        (rst_i),
  .trip_cond_i  (trip_cond_i),
  .cyc_i        (cyc_i),
  .stb_i        (stb_i),
  .we_i         (we_i),
  .adr_i        (adr_i),
  .sel_i        (sel_i),
  .dat_i        (dat_i),
  .dat_o        (dat_o),
  .ack_o        (ack_o),
  .first_trip_o (first_trip_o),
  .stop_o       (stop_o)
);

// ---- test/trip_status_history_logger_bench.sv ----
// Self-checking bench for the trip logger, bus driven directly.
// Assumes the design files and trip_checker.sv are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module trip_status_history_logger_bench;
  import trip_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, stop_o;
  trip_word_t  trip_cond_i, warn_cond_i;
  logic [5:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  trip_code_t  first_trip_o;
  int          n_fail, n_compared;

  trip_status_history_logger dut (.clk_i, .rst_i, .trip_cond_i,
    .warn_cond_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .first_trip_o, .stop_o);

  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end
  // ==========================================================
  // Bus and report tasks
  task end_sim;
    $display("fails %0d compares %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1; stb_i <= 1'h1; we_i <= w; adr_i <= a; dat_i <= d;
    // Ack and read data are taken at the rising edge that sees ack high;
    // the request is released at that same edge
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'h1 && k < 20);
    if (ack_o !== 1'h1) begin
      n_fail++;
      end_sim;
    end
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0000_0000);
    `CHK(q, e)
  endtask
  // ==========================================================
  // Scenarios
  task t_first;
    @(posedge clk_i);
    trip_cond_i <= 16'h0028;
    @(posedge clk_i);
    trip_cond_i <= 16'h002A;
    rd(6'h04, 32'h0000_0003);
    `CHK(stop_o, 1'h1)
    `CHK(first_trip_o, 4'h3)
    rd(6'h02, 32'h0000_002A);
    @(posedge clk_i);
    trip_cond_i <= 16'h0000;
    wb(1'h1, 6'h00, 32'h0000_0001);
    rd(6'h04, 32'h0000_0000);
  endtask
  task t_dis;
    wb(1'h1, 6'h01, 32'h0000_FFFF);
    rd(6'h01, 32'h0000_FFFF);
    @(posedge clk_i);
    trip_cond_i <= 16'hFDE0;
    warn_cond_i <= 16'hC20B;
    rd(6'h02, 32'h0000_0000);
    rd(6'h04, 32'h0000_0000);
    rd(6'h03, 32'h0000_020A);
    rd(6'h3F, 32'h0000_0000);
    @(posedge clk_i);
    trip_cond_i <= 16'h3FFE;
    rd(6'h02, 32'h0000_021E);
    rd(6'h04, 32'h0000_0001);
    @(posedge clk_i);
    trip_cond_i <= 16'h0000;
    wb(1'h1, 6'h00, 32'h0000_0001);
    // Upper byte lane only: the low byte of the mask must stay set
    sel_i <= 4'h2;
    wb(1'h1, 6'h01, 32'h0000_0000);
    sel_i <= 4'hF;
    rd(6'h01, 32'h0000_00FF);
    wb(1'h1, 6'h01, 32'h0000_0000);
  endtask
  task t_hist;
    // Eleven trips, each held for several cycles, must push once apiece
    for (int i = 1; i <= 11; i++) begin
      @(posedge clk_i);
      trip_cond_i <= 16'h0001 << i;
      repeat (4) @(posedge clk_i);
      trip_cond_i <= 16'h0000;
      wb(1'h1, 6'h00, 32'h0000_0001);
    end
    // A reset in mid-run must leave the history untouched
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(6'h04, 32'h0000_0000);
    rd(6'h08, 32'h0000_000B);
    for (int s = 1; s < 10; s++) begin
      rd(6'h08 + 6'(s), 32'(11 - s));
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst_i = 1'h1;
    cyc_i = 1'h0;
    stb_i = 1'h0;
    we_i = 1'h0;
    adr_i = 6'h00;
    sel_i = 4'hF;
    dat_i = 32'h0000_0000;
    trip_cond_i = 16'h0000;
    warn_cond_i = 16'h0000;
    n_fail = 0;
    n_compared = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h1, 6'h00, 32'h0000_0002);
    rd(6'h11, 32'h0000_0000);
    t_first;
    t_dis;
    t_hist;
    end_sim;
  end
endmodule
